/* clic_top.sv */
// Purpose: master/slave legacy interrupt controller pair with ack sequencer
// Assumes: i_io is on this clock; end-of-service is a non-specific command
//   write of 8'h20 to a base port; edge/level select and general control
//   arrive as plain inputs from their own registers
// Notes: rotation, poll and special mask are not implemented
`timescale 1ns/1ps
`default_nettype none
module clic_top import clic_pkg::*; #(
  parameter int N_IN = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [N_IN-1:0] i_irq,
  input wire logic [N_IN-1:0] i_level_sel,
  input wire logic [15:0] i_gen_ctl,
  input wire logic i_kbd_latch_clr,
  input wire clic_io_t i_io,
  input wire logic i_ack_cycle,
  output logic o_cpu_interrupt_out,
  output logic [7:0] o_rd_data,
  output logic o_vector_valid,
  output logic [7:0] o_vector,
  output logic o_internal_ack_pulse,
  output logic [2:0] o_cascade_code
);
  if (N_IN != 16) begin : g_chk
    $error("clic_top serves exactly two 8-input controllers");
  end

  // end-of-service command value written to a base port
  localparam logic [7:0] EOS_CMD = 8'h20;

  // lowest set bit among allowed ones; used for priority and for ack
  function automatic logic [3:0] pick(input logic [7:0] v);
    pick = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) begin
        pick = {1'b0, 3'(k)};
      end
    end
  endfunction

  // requests allowed past mask and the nested in-service block
  function automatic logic [7:0] eligible(input clic_ctl_t c);
    logic [7:0] blk;
    blk = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (c.in_service_bits[k]) begin
        blk = blk | (8'hff << k);
      end
    end
    eligible = c.req & ~c.mask & ~blk;
  endfunction

  // two-flop input synchroniser then previous sample for edges
  logic [N_IN-1:0] s1_r, s2_r, prev_r, s1_nxt, s2_nxt, prev_nxt;
  logic [N_IN-1:0] armed_r, armed_nxt, hold_r, hold_nxt;
  always_comb begin
    s1_nxt = i_irq;
    s2_nxt = s1_r;
    prev_nxt = s2_r;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      prev_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      prev_r <= prev_nxt;
    end
  end

  // optional keyboard/mouse latch, reloaded from the pin by the latch clear strobe
  logic [N_IN-1:0] line;
  always_comb begin
    hold_nxt = hold_r;
    if (i_gen_ctl[CLIC_KBD_LATCH_BIT] && s2_r[CLIC_KBD_INPUT])
      hold_nxt[CLIC_KBD_INPUT] = 1'b1;
    if (i_gen_ctl[CLIC_MOUSE_LATCH_BIT] && s2_r[CLIC_MOUSE_INPUT])
      hold_nxt[CLIC_MOUSE_INPUT] = 1'b1;
    if (i_kbd_latch_clr) begin
      hold_nxt[CLIC_KBD_INPUT] = s2_r[CLIC_KBD_INPUT];
      hold_nxt[CLIC_MOUSE_INPUT] = s2_r[CLIC_MOUSE_INPUT];
    end
    line = s2_r | hold_r;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // level mode per input, with fixed inputs overriding the select
  logic [N_IN-1:0] lvl, rise, raw;
  assign lvl = (i_level_sel & ~CLIC_FIXED_EDGE) | CLIC_FIXED_LEVEL;
  assign rise = s2_r & ~prev_r;

  // controllers, ack sequencer
  clic_ctl_t ctl_r [2], ctl_nxt [2];
  clic_ack_t ack_r, ack_nxt;
  logic [0:0] cnt_r, cnt_nxt;
  logic [3:0] win_r, win_nxt; // frozen winner index, none is stored as spurious input 7
  logic sel_slv_r, sel_slv_nxt;
  logic [2:0] code_nxt;
  logic [7:0] vec_nxt, rd_nxt;
  logic int_nxt, vv_nxt, pulse_nxt;
  logic [7:0] el_m, el_s, sreq;
  logic [3:0] pm, ps;

  always_comb begin
    // slave output feeds master input 2
    el_s = eligible(ctl_r[1]);
    ps = pick(el_s);
    sreq = raw[7:0];
    sreq[CLIC_CASCADE_INPUT] = (el_s != 8'h00);
    el_m = eligible(ctl_r[0]);
    pm = pick(el_m);
  end

  // request sources: edges need re-arming after init, levels do not
  always_comb begin
    armed_nxt = armed_r | ~s2_r;
    for (int c = 0; c < 2; c++) begin
      if (i_io.wr && i_io.addr == (c == 0 ? CLIC_MASTER_BASE
          : CLIC_SLAVE_BASE) && i_io.data[CLIC_INIT_START_BIT])
        armed_nxt[c*8 +: 8] = 8'h00;
    end
    raw = (lvl & line) | (~lvl & rise & armed_r);
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ctl_nxt[c] = ctl_r[c];
    end
    // set first, so a clear in the same cycle overrides it below, for the
    // acknowledged level itself and for all requests on an init write
    ctl_nxt[0].req = (ctl_r[0].req | sreq) & ~8'(1 << CLIC_CASCADE_INPUT);
    ctl_nxt[0].req[CLIC_CASCADE_INPUT] = sreq[CLIC_CASCADE_INPUT];
    ctl_nxt[1].req = ctl_r[1].req | raw[15:8];
    // level requests follow the line when it drops
    ctl_nxt[0].req = ctl_nxt[0].req & (~lvl[7:0] | line[7:0] | sreq);
    ctl_nxt[1].req = ctl_nxt[1].req & (~lvl[15:8] | line[15:8]);
    ack_nxt = ack_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    sel_slv_nxt = sel_slv_r;
    code_nxt = o_cascade_code;
    vec_nxt = o_vector;
    vv_nxt = 1'b0;
    pulse_nxt = 1'b0;
    rd_nxt = o_rd_data;
    // register port writes and reads
    for (int c = 0; c < 2; c++) begin
      logic [7:0] base, data;
      base = (c == 0) ? CLIC_MASTER_BASE : CLIC_SLAVE_BASE;
      data = (c == 0) ? CLIC_MASTER_DATA : CLIC_SLAVE_DATA;
      if (i_io.wr && i_io.addr == base) begin
        if (i_io.data[CLIC_INIT_START_BIT]) begin
          ctl_nxt[c].init = CLIC_INIT_VEC;
          ctl_nxt[c].mask = CLIC_ZERO8;
          ctl_nxt[c].cas = {5'h00, CLIC_SLAVE_ADDR_RST};
          ctl_nxt[c].rd_isr = 1'b0;
          ctl_nxt[c].req = CLIC_ZERO8;
        end else if (i_io.data == EOS_CMD) begin
          ctl_nxt[c].in_service_bits = ctl_r[c].in_service_bits & ~8'(1 << pick(ctl_r[c].in_service_bits));
        end else if (i_io.data[1:0] == 2'b10) begin
          ctl_nxt[c].rd_isr = i_io.data[0];
        end else if (i_io.data[1:0] == 2'b11) begin
          ctl_nxt[c].rd_isr = 1'b1;
        end
      end
      if (i_io.wr && i_io.addr == data) begin
        case (ctl_r[c].init)
          CLIC_INIT_VEC: begin
            ctl_nxt[c].vbase = i_io.data[7:3];
            ctl_nxt[c].init = CLIC_INIT_CAS;
          end
          CLIC_INIT_CAS: begin
            ctl_nxt[c].cas = i_io.data;
            ctl_nxt[c].init = CLIC_INIT_FIN;
          end
          CLIC_INIT_FIN: begin
            ctl_nxt[c].auto_end_of_service = i_io.data[CLIC_FINAL_AUTO_END_OF_SERVICE_BIT];
            ctl_nxt[c].init = CLIC_INIT_IDLE;
          end
          default: ctl_nxt[c].mask = i_io.data;
        endcase
      end
      if (i_io.rd && i_io.addr == base)
        rd_nxt = ctl_r[c].rd_isr ? ctl_r[c].in_service_bits : ctl_r[c].req;
      if (i_io.rd && i_io.addr == data)
        rd_nxt = ctl_r[c].mask;
    end
    // acknowledge sequencer: pulse, gap, pulse
    case (ack_r)
      CLIC_ACK_IDLE: begin
        if (i_ack_cycle) begin
          ack_nxt = CLIC_ACK_P1;
          cnt_nxt = '0;
          win_nxt = pm;
          pulse_nxt = 1'b1;
          if (pm[3]) begin
            win_nxt = 4'(CLIC_SPURIOUS_INPUT);
          end else begin
            ctl_nxt[0].in_service_bits[pm[2:0]] = 1'b1;
            ctl_nxt[0].req[pm[2:0]] = 1'b0;
            if (pm[2:0] == 3'(CLIC_CASCADE_INPUT) && !ps[3]) begin
              ctl_nxt[1].in_service_bits[ps[2:0]] = 1'b1;
              ctl_nxt[1].req[ps[2:0]] = 1'b0;
            end
          end
          sel_slv_nxt = (pm[2:0] == 3'(CLIC_CASCADE_INPUT)) && !pm[3]
              && !ps[3];
          if (pm[2:0] == 3'(CLIC_CASCADE_INPUT) && !pm[3])
            win_nxt = ps[3] ? 4'(CLIC_SPURIOUS_INPUT) : ps;
        end
      end
      CLIC_ACK_P1: begin
        pulse_nxt = (cnt_r != 1'(CLIC_ACK_LEN - 1));
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == 1'(CLIC_ACK_LEN - 1)) begin
          ack_nxt = CLIC_ACK_GAP;
          // trailing edge of first pulse: broadcast slave code
          code_nxt = sel_slv_r ? CLIC_SLAVE_CODE : 3'h0;
        end
      end
      CLIC_ACK_GAP: begin
        ack_nxt = CLIC_ACK_P2;
        pulse_nxt = 1'b1;
        if (code_nxt == ctl_r[1].cas[2:0] && sel_slv_r)
          vec_nxt = {ctl_r[1].vbase, win_r[2:0]};
        else
          vec_nxt = {ctl_r[0].vbase, sel_slv_r ? 3'(CLIC_SPURIOUS_INPUT)
              : win_r[2:0]};
        vv_nxt = 1'b1;
      end
      CLIC_ACK_P2: begin
        ack_nxt = CLIC_ACK_DONE;
      end
      CLIC_ACK_DONE: begin
        ack_nxt = CLIC_ACK_IDLE;
        code_nxt = 3'h0;
        // auto mode: master in-service ends after the second pulse; the slave's auto bit is unused
        if (ctl_r[0].auto_end_of_service) begin
          ctl_nxt[0].in_service_bits = ctl_r[0].in_service_bits & ~8'(1 << pick(ctl_r[0].in_service_bits));
        end
      end
      default: ack_nxt = CLIC_ACK_IDLE;
    endcase
    int_nxt = (el_m != 8'h00) && (ack_r == CLIC_ACK_IDLE);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        ctl_r[c] <= '{req: 8'h00, in_service_bits: 8'h00, mask: 8'h00, vbase: 5'h00,
            cas: 8'h00, auto_end_of_service: 1'b0, rd_isr: 1'b0, init: CLIC_INIT_IDLE};
      end
      armed_r <= '0;
      ack_r <= CLIC_ACK_IDLE;
      cnt_r <= '0;
      win_r <= 4'h0;
      sel_slv_r <= 1'b0;
      o_cascade_code <= 3'h0;
      o_vector <= 8'h00;
      o_vector_valid <= 1'b0;
      o_internal_ack_pulse <= 1'b0;
      o_rd_data <= 8'h00;
      o_cpu_interrupt_out <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      armed_r <= armed_nxt;
      ack_r <= ack_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      sel_slv_r <= sel_slv_nxt;
      o_cascade_code <= code_nxt;
      o_vector <= vec_nxt;
      o_vector_valid <= vv_nxt;
      o_internal_ack_pulse <= pulse_nxt;
      o_rd_data <= rd_nxt;
      o_cpu_interrupt_out <= int_nxt;
    end
  end
endmodule // clic_top
`default_nettype wire

/* clic_pkg.sv */
// Purpose: shared constants and carriers for the cascaded interrupt controller
// Assumes: one system clock, synchronous active-high reset
// Notes: i/o offsets are byte port addresses on the documented i/o space
`default_nettype none
package clic_pkg;
  localparam logic [7:0] CLIC_MASTER_BASE = 8'h20;
  localparam logic [7:0] CLIC_MASTER_DATA = 8'h21;
  localparam logic [7:0] CLIC_SLAVE_BASE = 8'ha0;
  localparam logic [7:0] CLIC_SLAVE_DATA = 8'ha1;
  localparam int CLIC_INIT_START_BIT = 4;
  localparam int CLIC_FINAL_AUTO_END_OF_SERVICE_BIT = 1;
  localparam int CLIC_CASCADE_INPUT = 2;
  localparam int CLIC_SPURIOUS_INPUT = 7;
  localparam logic [2:0] CLIC_SLAVE_CODE = 3'h2;
  localparam logic [2:0] CLIC_SLAVE_ADDR_RST = 3'h7;
  localparam int CLIC_KBD_LATCH_BIT = 11;
  localparam int CLIC_MOUSE_LATCH_BIT = 12;
  localparam int CLIC_KBD_INPUT = 1;
  localparam int CLIC_MOUSE_INPUT = 12;
  localparam logic [15:0] CLIC_FIXED_EDGE = 16'h2005; // 0,2,13 edge-only
  localparam logic [15:0] CLIC_FIXED_LEVEL = 16'h0100; // input 8 fixed
  localparam int CLIC_ACK_LEN = 2; // cycles of the first internal ack pulse; the second lasts one
  localparam logic [7:0] CLIC_ZERO8 = 8'h00;
  // init sequence position per controller
  typedef enum logic [3:0] {
    CLIC_INIT_IDLE = 4'b0001,
    CLIC_INIT_VEC = 4'b0010,
    CLIC_INIT_CAS = 4'b0100,
    CLIC_INIT_FIN = 4'b1000
  } clic_init_t;
  // acknowledge sequencer
  typedef enum logic [4:0] {
    CLIC_ACK_IDLE = 5'b00001,
    CLIC_ACK_P1 = 5'b00010,
    CLIC_ACK_GAP = 5'b00100,
    CLIC_ACK_P2 = 5'b01000,
    CLIC_ACK_DONE = 5'b10000
  } clic_ack_t;
  // i/o access from the device's port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } clic_io_t;
  // per-controller programmed state
  typedef struct packed {
    logic [7:0] req;
    logic [7:0] in_service_bits;
    logic [7:0] mask;
    logic [4:0] vbase;
    logic [7:0] cas;
    logic auto_end_of_service;
    logic rd_isr;
    clic_init_t init;
  } clic_ctl_t;
endpackage : clic_pkg
`default_nettype wire

/* clic_monitor.sv */
// Purpose: port checker for the cascaded interrupt controller pair
// Assumes: ack sequence of five cycles as handed over by the designer
// Notes: a helper counter mirrors the busy window of the ack sequencer
`timescale 1ns/1ps
`default_nettype none
module clic_monitor import clic_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire clic_io_t i_io,
  input wire logic i_ack_cycle,
  input wire logic o_cpu_interrupt_out,
  input wire logic [7:0] o_rd_data,
  input wire logic o_vector_valid,
  input wire logic [7:0] o_vector,
  input wire logic o_internal_ack_pulse,
  input wire logic [2:0] o_cascade_code
);
  default clocking mon_cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [2:0] busy_r, busy_nxt;
  logic acc;
  // an ack is only taken while no sequence runs; later ones are ignored
  always_comb begin
    acc = i_ack_cycle && (busy_r == 3'h0);
    busy_nxt = (busy_r != 3'h0) ? busy_r - 3'h1 : busy_r;
    if (acc) begin
      busy_nxt = 3'h5;
    end
    if (i_sys_rst) begin
      busy_nxt = 3'h0;
    end
  end
  // register only
  always_ff @(posedge i_clk_sys) begin
    busy_r <= busy_nxt;
  end
  a_ack_two_pulses: assert property (acc |=> o_internal_ack_pulse[*2]
    ##1 !o_internal_ack_pulse ##1 (o_internal_ack_pulse && o_vector_valid))
    else $error("ack pulse sequence wrong");
  a_vec_after_ack: assert property (o_vector_valid |-> $past(acc, 4))
    else $error("vector without ack");
  a_pulse_has_cause: assert property (
    o_internal_ack_pulse |-> busy_r != 3'h0)
    else $error("ack pulse outside a sequence");
  a_code_legal: assert property (
    o_cascade_code == 3'h0 || o_cascade_code == CLIC_SLAVE_CODE)
    else $error("bad cascade code");
  a_code_window: assert property (o_cascade_code != 3'h0 |->
    $past(acc, 3) || $past(acc, 4) || $past(acc, 5))
    else $error("cascade code outside its window");
  a_vector_holds: assert property (!o_vector_valid |-> $stable(o_vector))
    else $error("vector changed without valid");
  a_rd_on_request: assert property (
    !$past(i_io.rd) |-> $stable(o_rd_data))
    else $error("read data changed without read");
  a_quiet_after_rst: assert property ($fell(i_sys_rst) |->
    !o_cpu_interrupt_out && !o_vector_valid && !o_internal_ack_pulse &&
    o_cascade_code == 3'h0)
    else $error("outputs active after reset");
  c_ack: cover property (acc);
  c_slave: cover property (o_vector_valid && o_cascade_code != 3'h0);
  c_rd: cover property (i_io.rd);
endmodule // clic_monitor
bind clic_top clic_monitor mon_u (.i_clk_sys, .i_sys_rst, .i_io,
  .i_ack_cycle, .o_cpu_interrupt_out, .o_rd_data, .o_vector_valid,
  .o_vector, .o_internal_ack_pulse, .o_cascade_code);
`default_nettype wire

/* clic_cpu_model.sv */
// Purpose: processor model answering the interrupt output with acks
// Assumes: one ack cycle pulse per interrupt, answered by a vector
// Notes: i_delay of at least 1; a slow answer may find the request gone
`timescale 1ns/1ps
`default_nettype none
module clic_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_en,
  input wire logic [3:0] i_delay,
  input wire logic i_interrupt,
  input wire logic i_vector_valid,
  input wire logic [7:0] i_vector,
  output logic o_ack_cycle,
  output logic [7:0] o_vec,
  output logic [7:0] o_count
);
  logic [3:0] wait_r, wait_nxt;
  logic busy_r, busy_nxt, arm_r, arm_nxt, ack_nxt;
  logic [7:0] vec_nxt, cnt_nxt;
  // after each vector a short pause, since the output is registered
  always_comb begin
    {wait_nxt, busy_nxt, arm_nxt, ack_nxt} = {wait_r, busy_r, arm_r, 1'b0};
    {vec_nxt, cnt_nxt} = {o_vec, o_count};
    if (busy_r) begin
      if (i_vector_valid) begin
        {busy_nxt, vec_nxt, wait_nxt} = {1'b0, i_vector, 4'h3};
        cnt_nxt = o_count + 8'h01;
      end
    end else if (wait_r != 4'h0) begin
      wait_nxt = wait_r - 4'h1;
      if (arm_r && wait_r == 4'h1) begin
        {ack_nxt, busy_nxt, arm_nxt} = 3'b110;
      end
    end else if (i_en && i_interrupt) begin
      {wait_nxt, arm_nxt} = {i_delay, 1'b1};
    end
    if (i_sys_rst) begin
      {wait_nxt, busy_nxt, arm_nxt, ack_nxt, vec_nxt, cnt_nxt} = '0;
    end
  end
  // register only
  always_ff @(posedge i_clk_sys) begin
    {wait_r, busy_r, arm_r, o_ack_cycle} <=
      {wait_nxt, busy_nxt, arm_nxt, ack_nxt};
    {o_vec, o_count} <= {vec_nxt, cnt_nxt};
  end
endmodule // clic_cpu_model
`default_nettype wire

/* tb_cascaded_legacy_interrupt_controller.sv */
// Purpose: self-checking bench for the cascaded interrupt controller pair
// Assumes: master base 08h, slave base 70h; keyboard latch on only in t_latch
// Notes: acks come from the processor model, the bench enables it and sets its delay
`timescale 1ns/1ps
`default_nettype none
module tb_cascaded_legacy_interrupt_controller import clic_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] irq = '0;
  logic [15:0] lsel = '0;
  logic [15:0] gctl = '0;
  logic kclr = 1'b0;
  clic_io_t io = '0;
  logic en = 1'b0;
  logic [3:0] dly = 4'h1;
  logic ack, cpu_interrupt_out, vv, pulse;
  logic [7:0] rdd, vec, mvec, mcnt;
  logic [2:0] code;
  int miscompares = 0;
  int compares = 0;
  clic_top dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_irq(irq),
    .i_level_sel(lsel), .i_gen_ctl(gctl), .i_kbd_latch_clr(kclr),
    .i_io(io), .i_ack_cycle(ack), .o_cpu_interrupt_out(cpu_interrupt_out),
    .o_rd_data(rdd), .o_vector_valid(vv), .o_vector(vec),
    .o_internal_ack_pulse(pulse), .o_cascade_code(code));
  clic_cpu_model cpu_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_en(en),
    .i_delay(dly), .i_interrupt(cpu_interrupt_out), .i_vector_valid(vv),
    .i_vector(vec), .o_ack_cycle(ack), .o_vec(mvec), .o_count(mcnt));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic iow(input logic [7:0] a, d);
    @(posedge clk);
    io <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    io <= '0;
  endtask
  // read data holds, so sampling late is safe
  task automatic rdchk(input string what, input logic [7:0] a, exp);
    @(posedge clk);
    io <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    io <= '0;
    repeat (2) @(posedge clk);
    #1 chk(what, rdd, exp);
  endtask
  task automatic quiet(input string what);
    logic hi;
    hi = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1 hi = hi | cpu_interrupt_out;
    end
    chk(what, {7'h00, hi}, 8'h00);
  endtask
  task automatic wait_vec(output logic [7:0] v, output logic slv);
    logic [7:0] c0;
    c0 = mcnt;
    slv = 1'b0;
    for (int i = 0; i < 200 && mcnt == c0; i++) begin
      @(posedge clk);
      #1 slv = slv | (code == CLIC_SLAVE_CODE);
    end
    v = mvec;
    if (mcnt == c0) begin
      miscompares++;
      $display("unexpected timeout waiting for vector");
      close_out();
    end
  endtask
  task automatic setup(input logic [7:0] fin);
    iow(CLIC_MASTER_BASE, 8'h11);
    iow(CLIC_MASTER_DATA, 8'h08);
    iow(CLIC_MASTER_DATA, 8'h04);
    iow(CLIC_MASTER_DATA, fin);
    iow(CLIC_SLAVE_BASE, 8'h11);
    iow(CLIC_SLAVE_DATA, 8'h70);
    iow(CLIC_SLAVE_DATA, 8'h02);
    iow(CLIC_SLAVE_DATA, 8'h01);
  endtask
  task automatic t_init();
    iow(CLIC_MASTER_DATA, 8'hff);
    rdchk("mask", CLIC_MASTER_DATA, 8'hff);
    setup(8'h01);
    rdchk("mask after init", CLIC_MASTER_DATA, 8'h00);
    rdchk("request status", CLIC_MASTER_BASE, 8'h00);
    $display("test init done");
  endtask
  task automatic t_mask();
    logic [7:0] v;
    logic s;
    iow(CLIC_MASTER_DATA, 8'h08);
    en <= 1'b1;
    irq[3] <= 1'b1;
    quiet("masked interrupt");
    rdchk("masked request", CLIC_MASTER_BASE, 8'h08);
    iow(CLIC_MASTER_DATA, 8'h00);
    wait_vec(v, s);
    chk("vector", v, 8'h0b);
    iow(CLIC_MASTER_BASE, 8'h0b);
    rdchk("in service", CLIC_MASTER_BASE, 8'h08);
    iow(CLIC_MASTER_BASE, 8'h0a);
    rdchk("acked request", CLIC_MASTER_BASE, 8'h00);
    iow(CLIC_MASTER_BASE, 8'h20);
    iow(CLIC_MASTER_BASE, 8'h0b);
    rdchk("after command", CLIC_MASTER_BASE, 8'h00);
    @(posedge clk);
    irq[3] <= 1'b0;
    $display("test mask done");
  endtask
  task automatic t_prio();
    logic [7:0] v;
    logic s;
    @(posedge clk);
    irq[5] <= 1'b1;
    irq[1] <= 1'b1;
    wait_vec(v, s);
    chk("first vector", v, 8'h09);
    quiet("nested interrupt");
    iow(CLIC_MASTER_BASE, 8'h20);
    wait_vec(v, s);
    chk("second vector", v, 8'h0d);
    iow(CLIC_MASTER_BASE, 8'h20);
    {irq[5], irq[1]} <= 2'b00;
    $display("test priority done");
  endtask
  task automatic t_slave();
    logic [7:0] v;
    logic s;
    @(posedge clk);
    irq[10] <= 1'b1;
    wait_vec(v, s);
    chk("slave vector", v, 8'h72);
    chk("cascade code", {7'h00, s}, 8'h01);
    iow(CLIC_SLAVE_BASE, 8'h20);
    iow(CLIC_MASTER_BASE, 8'h20);
    irq[10] <= 1'b0;
    $display("test slave done");
  endtask
  task automatic t_short();
    logic [7:0] v;
    logic s;
    @(posedge clk);
    {dly, lsel[4], irq[4]} <= {4'hc, 2'b11};
    for (int i = 0; i < 50 && cpu_interrupt_out !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (cpu_interrupt_out !== 1'b1) begin
      miscompares++;
      $display("unexpected timeout waiting for interrupt");
      close_out();
    end
    @(posedge clk);
    irq[4] <= 1'b0;
    wait_vec(v, s);
    chk("lost request vector", v, 8'h0f);
    @(posedge clk);
    {dly, lsel[4]} <= {4'h1, 1'b0};
    $display("test short request done");
  endtask
  // level input held by the keyboard latch after its pin drops
  task automatic t_latch();
    iow(CLIC_MASTER_DATA, 8'hff);
    iow(CLIC_MASTER_BASE, 8'h0a);
    gctl[CLIC_KBD_LATCH_BIT] <= 1'b1;
    lsel[CLIC_KBD_INPUT] <= 1'b1;
    irq[CLIC_KBD_INPUT] <= 1'b1;
    repeat (4) @(posedge clk);
    irq[CLIC_KBD_INPUT] <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk("latched request", CLIC_MASTER_BASE, 8'h02);
    @(posedge clk);
    kclr <= 1'b1;
    @(posedge clk);
    kclr <= 1'b0;
    rdchk("latch cleared", CLIC_MASTER_BASE, 8'h00);
    @(posedge clk);
    {gctl, lsel[CLIC_KBD_INPUT]} <= 17'h00000;
    $display("test latch done");
  endtask
  task automatic t_auto_end_of_service();
    logic [7:0] v;
    logic s;
    setup(8'h03);
    irq[6] <= 1'b1;
    wait_vec(v, s);
    chk("auto vector", v, 8'h0e);
    iow(CLIC_MASTER_BASE, 8'h0b);
    rdchk("auto in service", CLIC_MASTER_BASE, 8'h00);
    $display("test auto end done");
  endtask
  // free-running system clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_mask();
    t_prio();
    t_slave();
    t_short();
    t_latch();
    t_auto_end_of_service();
    close_out();
  end
endmodule // tb_cascaded_legacy_interrupt_controller
`default_nettype wire
